// ### reset_seq_pkg.sv
package reset_seq_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] WAKE_TEST_OFF     = 5'h00;
    localparam logic [4:0] HW_CONFIG_OFF     = 5'h04;
    localparam logic [4:0] PWR_MGMT_OFF      = 5'h08;
    localparam logic [4:0] PHY_CONTROL_OFF   = 5'h0C;
    localparam logic [4:0] PHY_STATUS_OFF    = 5'h10;
    localparam logic [4:0] EEPROM_CMD_OFF    = 5'h14;
    localparam logic [4:0] STRAP_STATUS_OFF  = 5'h18;

    // Field positions.
    localparam int unsigned SOFT_RESET_BIT   = 0;
    localparam int unsigned READY_BIT        = 0;
    localparam int unsigned PHY_RESET_BIT    = 10;
    localparam int unsigned PM_MODE_LSB      = 12;
    localparam int unsigned PHY_REG_RST_BIT  = 15;
    localparam int unsigned LINK_STATUS_BIT  = 2;
    localparam int unsigned EEPROM_BUSY_BIT  = 31;

    // Arbitrary pattern returned by the wake test register.
    localparam logic [31:0] WAKE_TEST_VALUE  = 32'h8765_4321;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
    localparam logic [1:0]  PM_MODE_ACTIVE   = 2'h0;
    localparam int unsigned STRAP_W          = 8;

    // Timing at a 200 MHz clock.
    localparam int unsigned CLK_KHZ          = 200000;
    localparam int unsigned HW_READY_TIME_MS = 22;
    localparam int unsigned SOFT_TIME_NS     = 2000;
    localparam int unsigned PHY_TIME_US      = 100;
    localparam int unsigned WAKE_TIME_MS     = 2;
    localparam int unsigned HW_READY_CYCLES  = HW_READY_TIME_MS * CLK_KHZ;
    localparam int unsigned SOFT_CYCLES      = (SOFT_TIME_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int unsigned PHY_CYCLES       = PHY_TIME_US * (CLK_KHZ / 1000);
    localparam int unsigned WAKE_CYCLES      = WAKE_TIME_MS * CLK_KHZ;
    localparam int unsigned TIMER_W          = 32;
    localparam int unsigned NUM_TIMERS       = 4;

    // Timer slots.
    localparam int unsigned T_HW   = 0;
    localparam int unsigned T_SOFT = 1;
    localparam int unsigned T_PHY  = 2;
    localparam int unsigned T_WAKE = 3;

    typedef enum logic [2:0] {
        PM_ACTIVE = 3'b001,
        PM_SLEEP  = 3'b010,
        PM_WAKING = 3'b100
    } pm_state_e;

    typedef struct packed {
        logic pll;
        logic host_bus_port;
        logic soft_reset_preserved;
        logic mac_interface_layer;
        logic mac;
        logic phy;
    } domain_reset_s;

    localparam domain_reset_s DOMAIN_ALL = 6'h3F;

endpackage : reset_seq_pkg

// ### seq_timer.sv
`timescale 1ns/100ps
`default_nettype none
module seq_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_start,
    input  wire logic [W-1:0] i_len,
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] count_reg;

    // A restart while running reloads the full length.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_reg <= '0;
        end else if (i_start) begin
            count_reg <= i_len;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    assign o_busy = (count_reg != '0);
    assign o_done = (count_reg == W'(1));
endmodule : seq_timer
`default_nettype wire

// ### ethernet_ctrl_reset_sequencer.sv
// What this block does
// (RULE1) Four reset sources: pin, soft, two PHY.
// (RULE2) Hardware reset hits every domain, reloads, latches.
// (RULE3) Soft reset spares PLL, PHY, straps, preserved.
// (RULE4) Pin driven low starts hardware reset.
// (RULE5) Ready reads zero during hardware reset.
// (RULE6) Host configures only after ready seen.
// (RULE7) Pin pulled high, unconnected means running.
// (RULE8) Host holds pin low 30 ms.
// (RULE9) Unused pin needs soft reset after power-up.
// (RULE10) Config bit 0 soft reset, self-clears 2 us.
// (RULE11) No soft reset before ready after power-on.
// (RULE12) Ready about 22 ms after internal reset.
// (RULE13) Wake write sets ready within 2 ms.
// (RULE14) Power bit 10 resets PHY, clears 100 us.
// (RULE15) PHY control bit 15 resets PHY, self-clears.
// (RULE16) Probe EEPROM after power-up, hardware, soft reset.
// (RULE17) Host waits for EEPROM busy clear.
// (RULE18) Host waits for link status after PHY reset.
// (RULE19) Any wake write while sleeping restores full power.
// (RULE20) Host only reads while ready is clear.
// (RULE21) Self-clearing bits read one while busy.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ethernet_ctrl_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned HW_READY_LEN = HW_READY_CYCLES,
    parameter int unsigned SOFT_LEN     = SOFT_CYCLES,
    parameter int unsigned PHY_LEN      = PHY_CYCLES,
    parameter int unsigned WAKE_LEN     = WAKE_CYCLES
) (
    input  wire logic               i_clk,
    input  wire logic               i_arst_n,
    input  wire logic               i_ext_reset_in_low,
    input  wire logic [STRAP_W-1:0] i_straps,
    input  wire logic               i_link_up,
    input  wire logic               i_eeprom_probe_done,
    input  wire logic [4:0]         i_address,
    input  wire logic               i_read,
    input  wire logic               i_write,
    input  wire logic [31:0]        i_writedata,
    input  wire logic [3:0]         i_byteenable,
    output logic [31:0]             o_readdata,
    output logic                    o_waitrequest,
    output domain_reset_s           o_domain_reset,
    output logic                    o_eeprom_reload,
    output logic                    o_ready
);
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
        hit = (addr[4:2] == off[4:2]);
    endfunction : hit

    logic                 ack_reg;
    logic                 wr_fire;
    logic                 rd_fire;
    logic                 por_pend_reg;
    logic                 pin_reg;
    logic                 hw_start;
    logic                 hw_active;
    logic                 soft_start;
    logic                 phy_start;
    logic                 wake_start;
    logic                 phy_bit_src_reg;
    logic                 phy_reg_src_reg;
    logic                 eeprom_busy_reg;
    logic                 ready_reg;
    logic                 sleep_req;
    logic [1:0]           pm_mode_reg;
    logic [STRAP_W-1:0]   strap_reg;
    logic [31:0]          rd_mux;
    domain_reset_s        domain_next;
    pm_state_e            pm_state_reg;
    logic [NUM_TIMERS-1:0] t_start;
    logic [NUM_TIMERS-1:0] t_busy;
    logic [NUM_TIMERS-1:0] t_done;
    logic [TIMER_W-1:0]   t_len [NUM_TIMERS];

    // One wait cycle per access; the answer stands at the edge where waitrequest is low.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (i_read | i_write) & ~ack_reg;
        end
    end

    assign o_waitrequest = (i_read | i_write) & ~ack_reg;
    assign wr_fire       = i_write & ack_reg;
    assign rd_fire       = i_read & ack_reg;

    // The pad carries the pull-up, so a floating pin arrives here high and the device runs.
    always_ff @(posedge i_clk or negedge i_arst_n) begin // [RULE7]
        if (!i_arst_n) begin
            pin_reg      <= 1'b1;
            por_pend_reg <= 1'b1;
        end else begin
            pin_reg      <= i_ext_reset_in_low;
            por_pend_reg <= 1'b0;
        end
    end

    // The ready delay is reloaded while the pin is low and in the cycle after its release.
    // An old delay therefore cannot run out in the middle of a new pin reset.
    assign hw_start  = por_pend_reg | ~i_ext_reset_in_low | ~pin_reg; // [RULE1] [RULE4]
    assign hw_active = ~i_ext_reset_in_low | por_pend_reg | t_busy[T_HW]; // [RULE4]

    // Soft resets wait for ready; they are refused while hardware reset runs.
    assign soft_start = wr_fire & hit(i_address, HW_CONFIG_OFF) & i_byteenable[0]
                      & i_writedata[SOFT_RESET_BIT] & ~hw_active & ready_reg; // [RULE10] [RULE1]
    assign phy_start  = wr_fire & ~hw_active & ready_reg & i_byteenable[1]
                      & ((hit(i_address, PWR_MGMT_OFF) & i_writedata[PHY_RESET_BIT])
                      | (hit(i_address, PHY_CONTROL_OFF) & i_writedata[PHY_REG_RST_BIT])); // [RULE14] [RULE15]
    assign sleep_req  = wr_fire & hit(i_address, PWR_MGMT_OFF) & i_byteenable[1] & ready_reg
                      & (i_writedata[PM_MODE_LSB +: 2] != PM_MODE_ACTIVE) & ~hw_active;
    assign wake_start = wr_fire & hit(i_address, WAKE_TEST_OFF)
                      & (pm_state_reg == PM_SLEEP) & ~hw_active; // [RULE19]

    assign t_start = {wake_start, phy_start, soft_start, hw_start};
    assign t_len[T_HW]   = TIMER_W'(HW_READY_LEN);
    assign t_len[T_SOFT] = TIMER_W'(SOFT_LEN);
    assign t_len[T_PHY]  = TIMER_W'(PHY_LEN);
    assign t_len[T_WAKE] = TIMER_W'(WAKE_LEN);

    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
        seq_timer #(
            .W (TIMER_W)
        ) u_timer (
            .i_clk    (i_clk),
            .i_arst_n (i_arst_n),
            .i_start  (t_start[g]),
            .i_len    (t_len[g]),
            .o_busy   (t_busy[g]),
            .o_done   (t_done[g])
        );
    end

    // Which PHY source is pending decides which bit reads back as one.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phy_bit_src_reg <= 1'b0;
            phy_reg_src_reg <= 1'b0;
        end else if (hw_active) begin
            phy_bit_src_reg <= 1'b0;
            phy_reg_src_reg <= 1'b0;
        end else if (phy_start) begin
            // A new request beats the end of the old one, since the timer reloads.
            phy_bit_src_reg <= phy_bit_src_reg | hit(i_address, PWR_MGMT_OFF); // [RULE21]
            phy_reg_src_reg <= phy_reg_src_reg | hit(i_address, PHY_CONTROL_OFF); // [RULE21]
        end else if (t_done[T_PHY]) begin
            phy_bit_src_reg <= 1'b0;
            phy_reg_src_reg <= 1'b0;
        end
    end

    // Power state; hardware reset and a wake write clear the mode, soft reset leaves it.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pm_state_reg <= PM_ACTIVE;
            pm_mode_reg  <= PM_MODE_ACTIVE;
        end else if (hw_active) begin
            pm_state_reg <= PM_ACTIVE;
            pm_mode_reg  <= PM_MODE_ACTIVE;
        end else begin
            case (pm_state_reg)
                PM_ACTIVE: begin
                    if (sleep_req) begin
                        pm_state_reg <= PM_SLEEP;
                        pm_mode_reg  <= i_writedata[PM_MODE_LSB +: 2];
                    end
                end
                PM_SLEEP: begin
                    if (wake_start) begin // [RULE19]
                        pm_state_reg <= PM_WAKING;
                        pm_mode_reg  <= PM_MODE_ACTIVE;
                    end
                end
                PM_WAKING: begin
                    if (t_done[T_WAKE]) begin // [RULE13]
                        pm_state_reg <= PM_ACTIVE;
                    end
                end
                default: begin
                    pm_state_reg <= PM_ACTIVE;
                end
            endcase
        end
    end

    // Ready falls for hardware reset and sleep, and rises after the timed delay.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ready_reg <= 1'b0;
        end else if (hw_start || (hw_active && !t_done[T_HW])) begin
            ready_reg <= 1'b0; // [RULE5]
        end else if (t_done[T_HW] || (pm_state_reg == PM_WAKING && t_done[T_WAKE])) begin
            ready_reg <= 1'b1; // [RULE5] [RULE12] [RULE13]
        end else if (sleep_req) begin
            ready_reg <= 1'b0;
        end
    end

    // Straps are caught by a clocked edge at the end of every hardware reset only.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strap_reg <= '0;
        end else if (t_done[T_HW]) begin
            strap_reg <= i_straps; // [RULE2]
        end
    end

    // The EEPROM probe is requested when a hardware or soft reset ends; new requests win.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_eeprom_reload <= 1'b0;
            eeprom_busy_reg <= 1'b1;
        end else begin
            o_eeprom_reload <= t_done[T_HW] | t_done[T_SOFT]; // [RULE16] [RULE2] [RULE3]
            if (t_done[T_HW] || t_done[T_SOFT] || hw_active) begin
                eeprom_busy_reg <= 1'b1; // [RULE16]
            end else if (i_eeprom_probe_done) begin
                eeprom_busy_reg <= 1'b0;
            end
        end
    end

    // Domain routing per reset source.
    always_comb begin
        domain_next                      = '0;
        domain_next.pll                  = hw_active; // [RULE2]
        domain_next.soft_reset_preserved = hw_active; // [RULE3]
        domain_next.host_bus_port        = hw_active | t_busy[T_SOFT]; // [RULE3]
        domain_next.mac_interface_layer  = hw_active | t_busy[T_SOFT]; // [RULE3]
        domain_next.mac                  = hw_active | t_busy[T_SOFT]; // [RULE3]
        domain_next.phy                  = hw_active | t_busy[T_PHY]; // [RULE14] [RULE15]
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_domain_reset <= DOMAIN_ALL;
        end else begin
            o_domain_reset <= domain_next;
        end
    end

    assign o_ready = ready_reg;

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_mux = '0;
        if (hit(i_address, WAKE_TEST_OFF)) begin
            rd_mux = WAKE_TEST_VALUE;
        end else if (hit(i_address, HW_CONFIG_OFF)) begin
            rd_mux[SOFT_RESET_BIT] = t_busy[T_SOFT]; // [RULE21] [RULE10]
        end else if (hit(i_address, PWR_MGMT_OFF)) begin
            rd_mux[READY_BIT]          = ready_reg;
            rd_mux[PHY_RESET_BIT]      = phy_bit_src_reg; // [RULE21] [RULE14]
            rd_mux[PM_MODE_LSB +: 2]   = pm_mode_reg;
        end else if (hit(i_address, PHY_CONTROL_OFF)) begin
            rd_mux[PHY_REG_RST_BIT]    = phy_reg_src_reg; // [RULE21] [RULE15]
        end else if (hit(i_address, PHY_STATUS_OFF)) begin
            rd_mux[LINK_STATUS_BIT]    = i_link_up & ~t_busy[T_PHY] & ~hw_active;
        end else if (hit(i_address, EEPROM_CMD_OFF)) begin
            rd_mux[EEPROM_BUSY_BIT]    = eeprom_busy_reg;
        end else if (hit(i_address, STRAP_STATUS_OFF)) begin
            rd_mux[STRAP_W-1:0]        = strap_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_readdata <= RDATA_RESET;
        end else if (i_read && !ack_reg) begin
            o_readdata <= rd_mux;
        end
    end

    property p_ready_low_hw;
        @(posedge i_clk) disable iff (!i_arst_n)
        (hw_active && !t_done[T_HW]) |=> !o_ready;
    endproperty
    a_ready_low_hw: assert property (p_ready_low_hw) else $error("ready set in hw reset"); // [RULE5]

    property p_pin_starts;
        @(posedge i_clk) disable iff (!i_arst_n)
        !i_ext_reset_in_low |=> o_domain_reset == DOMAIN_ALL && !o_ready;
    endproperty
    a_pin_starts: assert property (p_pin_starts) else $error("pin low did not reset"); // [RULE4]

    property p_soft_len;
        @(posedge i_clk) disable iff (!i_arst_n)
        $rose(t_busy[T_SOFT]) |-> t_busy[T_SOFT] [*2] ##[1:400] !t_busy[T_SOFT];
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset length wrong"); // [RULE10]

    property p_soft_spares;
        @(posedge i_clk) disable iff (!i_arst_n)
        (t_busy[T_SOFT] && !hw_active && !t_busy[T_PHY]) |=>
            o_domain_reset.mac && !o_domain_reset.pll && !o_domain_reset.phy
            && !o_domain_reset.soft_reset_preserved;
    endproperty
    a_soft_spares: assert property (p_soft_spares) else $error("soft reset routing wrong"); // [RULE3]

    property p_phy_only;
        @(posedge i_clk) disable iff (!i_arst_n)
        (t_busy[T_PHY] && !hw_active && !t_busy[T_SOFT]) |=>
            o_domain_reset.phy && !o_domain_reset.mac && !o_domain_reset.host_bus_port;
    endproperty
    a_phy_only: assert property (p_phy_only) else $error("phy reset routing wrong"); // [RULE14]

    property p_probe;
        @(posedge i_clk) disable iff (!i_arst_n)
        (t_done[T_HW] || t_done[T_SOFT]) |=> o_eeprom_reload && eeprom_busy_reg;
    endproperty
    a_probe: assert property (p_probe) else $error("eeprom probe missing"); // [RULE16]

    property p_wake;
        @(posedge i_clk) disable iff (!i_arst_n)
        wake_start |=> pm_state_reg == PM_WAKING && pm_mode_reg == PM_MODE_ACTIVE && !o_ready;
    endproperty
    a_wake: assert property (p_wake) else $error("wake write ignored"); // [RULE19]

    property p_wake_ready;
        @(posedge i_clk) disable iff (!i_arst_n)
        (pm_state_reg == PM_WAKING && t_done[T_WAKE] && !hw_active) |=> o_ready;
    endproperty
    a_wake_ready: assert property (p_wake_ready) else $error("ready late after wake"); // [RULE13]

    property p_readback;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_read && !ack_reg && hit(i_address, HW_CONFIG_OFF) && t_busy[T_SOFT])
            |=> o_readdata[SOFT_RESET_BIT];
    endproperty
    a_readback: assert property (p_readback) else $error("soft bit not read as one"); // [RULE21]

    c_hw_done:   cover property (@(posedge i_clk) disable iff (!i_arst_n) t_done[T_HW]);
    c_soft_done: cover property (@(posedge i_clk) disable iff (!i_arst_n) t_done[T_SOFT]);
    c_phy_done:  cover property (@(posedge i_clk) disable iff (!i_arst_n) t_done[T_PHY]);
    c_wake_done: cover property (@(posedge i_clk) disable iff (!i_arst_n)
                                 pm_state_reg == PM_WAKING && t_done[T_WAKE]);
endmodule : ethernet_ctrl_reset_sequencer
`default_nettype wire

// ### host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic        i_clk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output logic [4:0]       o_address,
    output logic             o_read,
    output logic             o_write,
    output logic [31:0]      o_writedata,
    output logic [3:0]       o_byteenable
);
    initial begin
        o_address = 5'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0000_0000;
        o_byteenable = 4'hF;
    end

    // No answer time is assumed, so a hung slave is left to the bench watchdog.
    task automatic take_edge();
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
    endtask : take_edge

    task automatic rd(input logic [4:0] a, output logic [31:0] d, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_address <= a;
        o_read <= 1'b1;
        take_edge();
        d = i_readdata;
        o_read <= 1'b0;
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [31:0] dat, input logic [3:0] be,
                      input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= dat;
        o_byteenable <= be;
        o_write <= 1'b1;
        take_edge();
        o_write <= 1'b0;
        // Released data lines must not keep showing the old word.
        o_writedata <= ~dat;
    endtask : wr

    // Software touches nothing else until the polled flag settles or limit reads have passed.
    task automatic wait_bit(input logic [4:0] a, input int b, input logic v, input int limit,
                            output bit ok);
        logic [31:0] d;
        ok = 1'b0;
        for (int n = 0; n < limit && !ok; n++) begin
            rd(a, d, 0);
            ok = (d[b] === v);
        end
    endtask : wait_bit
endmodule : host_model
`default_nettype wire

// ### ethernet_ctrl_reset_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_ctrl_reset_sequencer_tb;
    import reset_seq_pkg::*;
    localparam int HW_LEN = 50;
    localparam int SOFT_LEN_T = 10;
    localparam int PHY_LEN_T = 20;
    localparam int WAKE_LEN_T = 30;

    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               pin_n = 1'b1; // Idle high like the pulled-up pin.
    logic               link_up = 1'b1;
    logic               probe_done = 1'b0;
    logic [STRAP_W-1:0] straps = 8'h00;
    logic [4:0]         address;
    logic               rd_en;
    logic               wr_en;
    logic [31:0]        wdata;
    logic [3:0]         be;
    logic [31:0]        rdata;
    logic               waitreq;
    domain_reset_s      domains;
    logic               reload;
    logic               ready;
    int                 mismatches = 0;
    int                 samples_checked = 0;
    int                 reloads = 0;
    int                 seed = 57;

    initial begin
        forever #2.5 clk = ~clk;
    end

    ethernet_ctrl_reset_sequencer #(.HW_READY_LEN(HW_LEN), .SOFT_LEN(SOFT_LEN_T),
        .PHY_LEN(PHY_LEN_T), .WAKE_LEN(WAKE_LEN_T)) u_ethernet_ctrl_reset_sequencer (
        .i_clk(clk), .i_arst_n(arst_n), .i_ext_reset_in_low(pin_n), .i_straps(straps),
        .i_link_up(link_up), .i_eeprom_probe_done(probe_done), .i_address(address),
        .i_read(rd_en), .i_write(wr_en), .i_writedata(wdata), .i_byteenable(be),
        .o_readdata(rdata), .o_waitrequest(waitreq), .o_domain_reset(domains),
        .o_eeprom_reload(reload), .o_ready(ready));

    host_model u_host_model (
        .i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(address),
        .o_read(rd_en), .o_write(wr_en), .o_writedata(wdata), .o_byteenable(be));

    always @(posedge clk) begin
        if (reload === 1'b1) begin
            reloads <= reloads + 1;
        end
    end

    function automatic logic [5:0] exp_domains(input int kind);
        domain_reset_s d;
        d = '0;
        if (kind == 1) begin
            d = DOMAIN_ALL;
        end
        if (kind == 2) begin
            d.host_bus_port = 1'b1;
            d.mac_interface_layer = 1'b1;
            d.mac = 1'b1;
        end
        if (kind == 3) begin
            d.phy = 1'b1;
        end
        return d;
    endfunction : exp_domains

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Checked %0d values, %0d mismatches", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic rd_bit(input logic [4:0] a, input int b, input logic v);
        logic [31:0] d;
        u_host_model.rd(a, d, 0);
        check({31'h0, d[b]}, {31'h0, v});
    endtask : rd_bit

    task automatic probe_pulse();
        @(posedge clk);
        probe_done <= 1'b1;
        @(posedge clk);
        probe_done <= 1'b0;
    endtask : probe_pulse

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        logic [31:0]        d;
        logic [STRAP_W-1:0] s0;
        logic [STRAP_W-1:0] s1;
        logic [4:0]         a;
        bit                 ok;
        s0 = 8'($random(seed));
        straps = s0;
        repeat (16) @(posedge clk);
        check({31'h0, ready}, 32'h0);
        check({26'h0, domains}, {26'h0, exp_domains(1)});
        arst_n <= 1'b1;
        rd_bit(PWR_MGMT_OFF, READY_BIT, 1'b0);
        u_host_model.wait_bit(PWR_MGMT_OFF, READY_BIT, 1'b1, HW_LEN / 3 + 4, ok);
        check({31'h0, ok}, 32'h1);
        check({26'h0, domains}, 32'h0);
        u_host_model.rd(STRAP_STATUS_OFF, d, 0);
        check(d, {24'h0, s0});
        rd_bit(EEPROM_CMD_OFF, EEPROM_BUSY_BIT, 1'b1);
        probe_pulse();
        u_host_model.wait_bit(EEPROM_CMD_OFF, EEPROM_BUSY_BIT, 1'b0, 4, ok);
        check({31'h0, ok}, 32'h1);
        check(reloads, 1);
        s1 = 8'($random(seed));
        straps <= s1;
        for (int i = 0; i < 8; i++) begin
            u_host_model.wr(5'h1C, $random(seed), 4'($random(seed)), i % 3);
            u_host_model.rd(5'h1C, d, i % 2);
            check(d, 32'h0);
            u_host_model.rd(WAKE_TEST_OFF, d, 0);
            check(d, WAKE_TEST_VALUE);
        end
        // Lane 0 off means the soft reset bit is not written.
        u_host_model.wr(HW_CONFIG_OFF, 32'h0000_0001, 4'hE, 0);
        rd_bit(HW_CONFIG_OFF, SOFT_RESET_BIT, 1'b0);
        u_host_model.wr(HW_CONFIG_OFF, 32'h0000_0001, 4'hF, 0);
        rd_bit(HW_CONFIG_OFF, SOFT_RESET_BIT, 1'b1);
        check({26'h0, domains}, {26'h0, exp_domains(2)});
        u_host_model.wait_bit(HW_CONFIG_OFF, SOFT_RESET_BIT, 1'b0, SOFT_LEN_T / 3 + 4, ok);
        check({31'h0, ok}, 32'h1);
        rd_bit(EEPROM_CMD_OFF, EEPROM_BUSY_BIT, 1'b1);
        check(reloads, 2);
        check({31'h0, ready}, 32'h1);
        u_host_model.rd(STRAP_STATUS_OFF, d, 0);
        check(d, {24'h0, s0});
        probe_pulse();
        for (int k = 0; k < 2; k++) begin
            a = (k == 1) ? PHY_CONTROL_OFF : PWR_MGMT_OFF;
            d = 32'h1 << ((k == 1) ? PHY_REG_RST_BIT : PHY_RESET_BIT);
            u_host_model.wr(a, d, 4'hF, k);
            u_host_model.rd(a, d, 0);
            check(d & 32'h0000_8400, 32'h1 << ((k == 1) ? PHY_REG_RST_BIT : PHY_RESET_BIT));
            check({26'h0, domains}, {26'h0, exp_domains(3)});
            rd_bit(PHY_STATUS_OFF, LINK_STATUS_BIT, 1'b0);
            u_host_model.wait_bit(a, (k == 1) ? 15 : 10, 1'b0, PHY_LEN_T / 3 + 4, ok);
            check({31'h0, ok}, 32'h1);
            rd_bit(PHY_STATUS_OFF, LINK_STATUS_BIT, 1'b1);
        end
        link_up <= 1'b0;
        rd_bit(PHY_STATUS_OFF, LINK_STATUS_BIT, 1'b0);
        link_up <= 1'b1;
        u_host_model.wr(PWR_MGMT_OFF, 32'h0000_1000, 4'hF, 0);
        rd_bit(PWR_MGMT_OFF, READY_BIT, 1'b0);
        // Only the wake write may land while asleep.
        u_host_model.wr(HW_CONFIG_OFF, 32'h0000_0001, 4'hF, 0);
        rd_bit(HW_CONFIG_OFF, SOFT_RESET_BIT, 1'b0);
        u_host_model.wr(WAKE_TEST_OFF, $random(seed), 4'h0, 0);
        u_host_model.wait_bit(PWR_MGMT_OFF, READY_BIT, 1'b1, WAKE_LEN_T / 3 + 4, ok);
        check({31'h0, ok}, 32'h1);
        u_host_model.rd(PWR_MGMT_OFF, d, 0);
        check({30'h0, d[13:12]}, {30'h0, PM_MODE_ACTIVE});
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        check({31'h0, ready}, 32'h0);
        check({26'h0, domains}, {26'h0, exp_domains(1)});
        pin_n <= 1'b1;
        u_host_model.wait_bit(PWR_MGMT_OFF, READY_BIT, 1'b1, HW_LEN / 3 + 4, ok);
        check({31'h0, ok}, 32'h1);
        u_host_model.rd(STRAP_STATUS_OFF, d, 0);
        check(d, {24'h0, s1});
        check(reloads, 3);
        conclude();
    end
endmodule : ethernet_ctrl_reset_sequencer_tb
`default_nettype wire
